// ===== rtl/ipace_matcher.sv
/*
 ipv4 access control entry matcher: one entry's ipv4 criteria checked
 against each frame from the ingress parser, configured over axi4-lite.
 assumes the parser delivers one header per frame_valid pulse on sys_clk.
*/
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
// Notes on behaviour
// - ipv4 criteria apply only when the entry frame type is ipv4.
// - protocol mode any ignores the protocol field.
// - specific protocol mode hits only on the held 8-bit protocol value.
// - icmp, udp or tcp choices restrict to that protocol and flag layer 4.
// - ttl zero mode blocks frames with ttl above zero; any ignores ttl.
// - ttl nonzero mode hits only when ttl is above zero.
// - fragment no blocks frames with mf set or offset nonzero; any ignores.
// - fragment yes hits only when mf is set or offset is above zero.
// - options no blocks frames with options set; any ignores options.
// - options yes hits only when the options flag is set.
// - source host mode needs exact source address; any ignores it.
// - source network mode compares only the source mask bits.
// - destination host mode needs exact address; any ignores it.
// - destination network mode compares only the destination mask bits.
`default_nettype none
module ipace_matcher
	import ipace_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// frame from the ingress parser
	input wire logic frame_valid,
	input wire ipace_frame_t frame_hdr,
	// verdict to the pipeline
	output logic verdict_valid,
	output ipace_verdict_t verdict,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	typedef enum logic [1:0] {
		IPACE_RD_IDLE = 2'b00,
		IPACE_RD_WAIT = 2'b01,
		IPACE_RD_RESP = 2'b10
	} ipace_rdst_t;

	logic [31:0] ctrl_r, hits_r, last_r, w_data_r, mem_rd;
	logic [7:0] proto_r, aw_addr_r, ar_addr_r;
	logic aw_held_r, w_held_r, wr_go, mem_wr;
	logic [3:0] w_strb_r;
	logic [1:0] mem_wr_idx, mem_rd_idx;
	logic [127:0] words;
	ipace_rdst_t rd_st_r;

	// map a byte offset to an address word index, or flag it as none
	function automatic logic is_addr_word(input logic [7:0] a);
		return a == IPACE_SRC_ADDR_OFS || a == IPACE_SRC_MASK_OFS ||
			a == IPACE_DST_ADDR_OFS || a == IPACE_DST_MASK_OFS;
	endfunction

	function automatic logic [1:0] word_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - IPACE_SRC_ADDR_OFS;
		return d[3:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return is_addr_word(a) || a == IPACE_CTRL_OFS ||
			a == IPACE_PROTO_OFS || a == IPACE_STAT_OFS ||
			a == IPACE_HITS_OFS;
	endfunction

	// apply byte strobes to a word
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// write address and data are captured independently
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	assign mem_wr = wr_go && is_addr_word(aw_addr_r);
	assign mem_wr_idx = word_idx(aw_addr_r);

	// ready outputs registered: high while nothing is held and no write response is pending
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end

	// write response
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= IPACE_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr_r) ? IPACE_RESP_OKAY :
				IPACE_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control and protocol value registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_r <= IPACE_CTRL_RST;
			proto_r <= IPACE_PROTO_RST;
		end else if (wr_go && aw_addr_r == IPACE_CTRL_OFS) begin
			ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
		end else if (wr_go && aw_addr_r == IPACE_PROTO_OFS &&
				w_strb_r[0]) begin
			proto_r <= w_data_r[7:0];
		end
	end

	ipace_cfg_mem #(.WIDTH(32), .DEPTH(4)) u_mem (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr_en(mem_wr),
		.wr_idx(mem_wr_idx),
		.wr_data(w_data_r),
		.wr_strb(w_strb_r),
		.rd_idx(mem_rd_idx),
		.rd_data(mem_rd),
		.all_words(words)
	);

	assign mem_rd_idx = word_idx(rd_st_r == IPACE_RD_IDLE ? s_axi_araddr :
		ar_addr_r); // look up on the accept edge, memory is registered
	// read channel: accept, wait a cycle for memory, answer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_st_r <= IPACE_RD_IDLE;
			ar_addr_r <= 8'h00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= IPACE_RESP_OKAY;
		end else begin
			case (rd_st_r)
				IPACE_RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						ar_addr_r <= s_axi_araddr;
						s_axi_arready <= 1'b0;
						rd_st_r <= IPACE_RD_WAIT;
					end
				end
				IPACE_RD_WAIT: begin
					s_axi_rvalid <= 1'b1;
					s_axi_rresp <= is_mapped(ar_addr_r) ? IPACE_RESP_OKAY :
						IPACE_RESP_SLVERR;
					if (is_addr_word(ar_addr_r))
						s_axi_rdata <= mem_rd;
					else if (ar_addr_r == IPACE_CTRL_OFS)
						s_axi_rdata <= ctrl_r;
					else if (ar_addr_r == IPACE_PROTO_OFS)
						s_axi_rdata <= {24'h000000, proto_r};
					else if (ar_addr_r == IPACE_STAT_OFS)
						s_axi_rdata <= last_r;
					else if (ar_addr_r == IPACE_HITS_OFS)
						s_axi_rdata <= hits_r;
					else
						s_axi_rdata <= 32'h0000_0000;
					rd_st_r <= IPACE_RD_RESP;
				end
				IPACE_RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_st_r <= IPACE_RD_IDLE;
					end
				end
				default: rd_st_r <= IPACE_RD_IDLE;
			endcase
		end
	end

	// decoded configuration
	ipace_ftype_t ftype;
	ipace_pmode_t pmode;
	ipace_tri_t ttl_m, frg_m, opt_m;
	ipace_amode_t src_m, dst_m;
	logic [31:0] src_addr, src_mask, dst_addr, dst_mask;

	assign ftype = ipace_ftype_t'(ctrl_r[IPACE_FT_POS +: 2]);
	assign pmode = ipace_pmode_t'(ctrl_r[IPACE_PM_POS +: 3]);
	assign ttl_m = ipace_tri_t'(ctrl_r[IPACE_TTL_POS +: 2]);
	assign frg_m = ipace_tri_t'(ctrl_r[IPACE_FRG_POS +: 2]);
	assign opt_m = ipace_tri_t'(ctrl_r[IPACE_OPT_POS +: 2]);
	assign src_m = ipace_amode_t'(ctrl_r[IPACE_SRC_POS +: 2]);
	assign dst_m = ipace_amode_t'(ctrl_r[IPACE_DST_POS +: 2]);
	assign src_addr = words[31:0];
	assign src_mask = words[63:32];
	assign dst_addr = words[95:64];
	assign dst_mask = words[127:96];

	// address criterion check shared by source and destination
	function automatic logic addr_ok(input ipace_amode_t m,
			input logic [31:0] f, input logic [31:0] a,
			input logic [31:0] k);
		case (m)
			IPACE_AM_ANY: return 1'b1;
			IPACE_AM_HOST: return f == a;
			IPACE_AM_NET: return (f & k) == (a & k);
			default: return 1'b0;
		endcase
	endfunction

	// three-way flag criterion check
	function automatic logic tri_ok(input ipace_tri_t m, input logic v);
		case (m)
			IPACE_TRI_ANY: return 1'b1;
			IPACE_TRI_NO: return !v;
			IPACE_TRI_YES: return v;
			default: return 1'b0;
		endcase
	endfunction

	logic is_v4, p_ok, t_ok, f_ok, o_ok, s_ok, d_ok, hit_nxt;
	logic is_frag, l4_go;

	assign is_v4 = frame_hdr.ftype == IPACE_FT_IPV4;
	assign is_frag = frame_hdr.more_frag || frame_hdr.frag_ofs != 13'h0;

	// protocol criterion
	always_comb begin
		case (pmode)
			IPACE_PM_ANY: p_ok = 1'b1;
			IPACE_PM_SPECIFIC: p_ok = frame_hdr.proto == proto_r;
			IPACE_PM_ICMP: p_ok = frame_hdr.proto == IPACE_PROTO_ICMP;
			IPACE_PM_UDP: p_ok = frame_hdr.proto == IPACE_PROTO_UDP;
			IPACE_PM_TCP: p_ok = frame_hdr.proto == IPACE_PROTO_TCP;
			default: p_ok = 1'b0;
		endcase
	end

	// header flag and address criteria
	assign t_ok = tri_ok(ttl_m, frame_hdr.ttl != 8'h00);
	assign f_ok = tri_ok(frg_m, is_frag);
	assign o_ok = tri_ok(opt_m, frame_hdr.has_opts);
	assign s_ok = addr_ok(src_m, frame_hdr.src_ip, src_addr, src_mask);
	assign d_ok = addr_ok(dst_m, frame_hdr.dst_ip, dst_addr, dst_mask);
	assign l4_go = frame_valid && hit_nxt && ftype == IPACE_FT_IPV4;

	// combine: ipv4 entries check ipv4 criteria, others only frame type
	always_comb begin
		if (ftype == IPACE_FT_IPV4)
			hit_nxt = is_v4 && p_ok && t_ok && f_ok && o_ok && s_ok && d_ok;
		else if (ftype == IPACE_FT_ANY)
			hit_nxt = 1'b1;
		else
			hit_nxt = ftype == IPACE_FT_OTHER && !is_v4;
	end

	// registered verdict
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			verdict_valid <= 1'b0;
			verdict <= '0;
		end else begin
			verdict_valid <= frame_valid;
			verdict.hit <= frame_valid && hit_nxt;
			verdict.l4_icmp <= l4_go && pmode == IPACE_PM_ICMP;
			verdict.l4_udp <= l4_go && pmode == IPACE_PM_UDP;
			verdict.l4_tcp <= l4_go && pmode == IPACE_PM_TCP;
		end
	end

	// hit counter and last verdict status
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hits_r <= 32'h0000_0000;
			last_r <= 32'h0000_0000;
		end else if (frame_valid) begin
			hits_r <= hits_r + {31'h0, hit_nxt};
			last_r <= {24'h000000, 1'b1, p_ok, t_ok, f_ok, o_ok, s_ok, d_ok,
				hit_nxt};
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ipace_pkg.sv
/*
 package for the ipv4 access control entry matcher: register map,
 field positions, reset values, mode encodings and the frame carrier.
 assumes a single core clock and a 32-bit axi4-lite register bus.
*/
`default_nettype none
package ipace_pkg;
	// register byte offsets
	localparam logic [7:0] IPACE_CTRL_OFS = 8'h00;
	localparam logic [7:0] IPACE_PROTO_OFS = 8'h04;
	localparam logic [7:0] IPACE_SRC_ADDR_OFS = 8'h08;
	localparam logic [7:0] IPACE_SRC_MASK_OFS = 8'h0C;
	localparam logic [7:0] IPACE_DST_ADDR_OFS = 8'h10;
	localparam logic [7:0] IPACE_DST_MASK_OFS = 8'h14;
	localparam logic [7:0] IPACE_STAT_OFS = 8'h18;
	localparam logic [7:0] IPACE_HITS_OFS = 8'h1C;
	// control field positions
	localparam int IPACE_FT_POS = 0;
	localparam int IPACE_PM_POS = 4;
	localparam int IPACE_TTL_POS = 8;
	localparam int IPACE_FRG_POS = 10;
	localparam int IPACE_OPT_POS = 12;
	localparam int IPACE_SRC_POS = 16;
	localparam int IPACE_DST_POS = 18;
	// reset values
	localparam logic [31:0] IPACE_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] IPACE_WORD_RST = 32'h0000_0000;
	localparam logic [7:0] IPACE_PROTO_RST = 8'h00;
	// protocol numbers for the layer-4 choices
	localparam logic [7:0] IPACE_PROTO_ICMP = 8'h01;
	localparam logic [7:0] IPACE_PROTO_TCP = 8'h06;
	localparam logic [7:0] IPACE_PROTO_UDP = 8'h11;
	// axi responses
	localparam logic [1:0] IPACE_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPACE_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		IPACE_FT_ANY = 2'b00,
		IPACE_FT_IPV4 = 2'b01,
		IPACE_FT_OTHER = 2'b10
	} ipace_ftype_t;

	typedef enum logic [2:0] {
		IPACE_PM_ANY = 3'b000,
		IPACE_PM_SPECIFIC = 3'b001,
		IPACE_PM_ICMP = 3'b010,
		IPACE_PM_UDP = 3'b011,
		IPACE_PM_TCP = 3'b100
	} ipace_pmode_t;

	// three-way criterion: any, zero/no, nonzero/yes
	typedef enum logic [1:0] {
		IPACE_TRI_ANY = 2'b00,
		IPACE_TRI_NO = 2'b01,
		IPACE_TRI_YES = 2'b10
	} ipace_tri_t;

	typedef enum logic [1:0] {
		IPACE_AM_ANY = 2'b00,
		IPACE_AM_HOST = 2'b01,
		IPACE_AM_NET = 2'b10
	} ipace_amode_t;

	// parsed header fields of one frame
	typedef struct packed {
		logic [1:0] ftype;
		logic [7:0] proto;
		logic [7:0] ttl;
		logic more_frag;
		logic [12:0] frag_ofs;
		logic has_opts;
		logic [31:0] src_ip;
		logic [31:0] dst_ip;
	} ipace_frame_t;

	// match verdict handed back to the pipeline
	typedef struct packed {
		logic hit;
		logic l4_icmp;
		logic l4_udp;
		logic l4_tcp;
	} ipace_verdict_t;
endpackage
`default_nettype wire

// ===== rtl/ipace_cfg_mem.sv
/*
 small register memory holding the address criterion words of the
 entry. read data come out of a register one cycle after the address.
 assumes the caller owns all writes and reads on the core clock.
*/
`default_nettype none
module ipace_cfg_mem
	import ipace_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [WIDTH/8-1:0] wr_strb,
	// registered read port
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	// all words in parallel for the comparators
	output logic [DEPTH*WIDTH-1:0] all_words
);
	// refuse geometries the byte lanes and index cannot serve
	if (WIDTH % 8 != 0 || DEPTH < 2) begin : g_bad_geom
		$error("ipace_cfg_mem: unsupported geometry");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];

	// byte-lane writes per word
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_word
			always_ff @(posedge sys_clk) begin
				if (sys_rst)
					mem_r[gi] <= WIDTH'(IPACE_WORD_RST);
				else if (wr_en && wr_idx == gi)
					for (int b = 0; b < WIDTH / 8; b++)
						if (wr_strb[b])
							mem_r[gi][b*8 +: 8] <= wr_data[b*8 +: 8];
			end
			assign all_words[gi*WIDTH +: WIDTH] = mem_r[gi];
		end
	endgenerate

	// registered read
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rd_data <= '0;
		else
			rd_data <= mem_r[rd_idx];
	end
endmodule
`default_nettype wire

// ===== testbench/ipace_matcher_asserts.sv
/*
 checks on the matcher frame path: verdict timing and layer-4 flags.
 assumes it is bound to ipace_matcher, one clock, sync reset.
*/
`default_nettype none
module ipace_matcher_asserts
	import ipace_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// frame path
	input wire logic frame_valid,
	input wire ipace_frame_t frame_hdr,
	input wire logic verdict_valid,
	input wire ipace_verdict_t verdict
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// one verdict per frame, exactly one cycle later
	AST_VLD_NEXT:
	assert property (frame_valid |=> verdict_valid)
		else $error("no verdict after frame");
	AST_VLD_ONLY:
	assert property (!frame_valid |=> !verdict_valid)
		else $error("verdict without frame");
	AST_IDLE_ZERO:
	assert property (!verdict_valid |-> verdict == '0)
		else $error("verdict not cleared");
	// layer-4 flags only for their protocol numbers
	AST_ICMP_NUM:
	assert property (frame_valid && frame_hdr.proto != 8'h01
		|=> !verdict.l4_icmp) else $error("icmp flag on wrong protocol");
	AST_TCP_NUM:
	assert property (frame_valid && frame_hdr.proto != 8'h06
		|=> !verdict.l4_tcp) else $error("tcp flag on wrong protocol");
	AST_UDP_NUM:
	assert property (frame_valid && frame_hdr.proto != 8'h11
		|=> !verdict.l4_udp) else $error("udp flag on wrong protocol");
	// a layer-4 flag needs a hit and stands alone
	AST_L4_HIT:
	assert property (verdict_valid && verdict[2:0] != 3'h0
		|-> verdict.hit && $onehot(verdict[2:0]))
		else $error("layer-4 flag without hit");
	// non-ipv4 frames never raise layer-4 flags
	AST_L4_IPV4:
	assert property (verdict_valid && $past(frame_hdr.ftype) != 2'h1
		|-> verdict[2:0] == 3'h0) else $error("layer-4 flag on non-ipv4");
	cover property (verdict_valid && verdict.hit);
	cover property (verdict_valid && !verdict.hit);
	cover property (verdict.l4_tcp);
endmodule
bind ipace_matcher ipace_matcher_asserts ipace_matcher_asserts_i (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .frame_valid(frame_valid),
	.frame_hdr(frame_hdr), .verdict_valid(verdict_valid),
	.verdict(verdict));
`default_nettype wire

// ===== testbench/ipace_parser_model.sv
/*
 ingress parser model: sends queued headers as one-cycle pulses,
 back to back or after idle gaps. assumes the bench queues by push.
*/
`default_nettype none
module ipace_parser_model
	import ipace_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// frame to the matcher
	output logic frame_valid,
	output ipace_frame_t frame_hdr
);
	timeunit 1ns;
	timeprecision 1ps;
	ipace_frame_t hdr_q[$];
	int gap_q[$];
	int idle = 0;
	// queue one header with idle cycles ahead of it
	task automatic push(input ipace_frame_t h, input int gap);
		hdr_q.push_back(h);
		gap_q.push_back(gap);
	endtask
	initial begin
		frame_valid = 1'b0;
		frame_hdr = '0;
	end
	// header lines invert between frames so stale values never match
	always @(posedge sys_clk) begin
		if (!sys_rst && hdr_q.size() != 0 && idle >= gap_q[0]) begin
			frame_valid <= 1'b1;
			frame_hdr <= hdr_q.pop_front();
			void'(gap_q.pop_front());
			idle = 0;
		end else begin
			frame_valid <= 1'b0;
			frame_hdr <= ~frame_hdr;
			idle++;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
/*
 self-checking bench: random entry setups and frames near them.
 assumes the parser model and the bound checker.
*/
`default_nettype none
module testbench
	import ipace_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, sys_rst, frame_valid, verdict_valid;
	ipace_frame_t frame_hdr, f;
	ipace_verdict_t verdict, ev;
	ipace_verdict_t exp_q[$];
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, ctrl, pv, sa, sm, da, dm, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int failures = 0, n_compared = 0, hits = 0;
	int pos[5] = '{IPACE_TTL_POS, IPACE_FRG_POS, IPACE_OPT_POS,
		IPACE_SRC_POS, IPACE_DST_POS};
	// 125 MHz core clock
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	ipace_matcher ipace_matcher_i (.sys_clk, .sys_rst, .frame_valid,
		.frame_hdr, .verdict_valid, .verdict, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	ipace_parser_model ipace_parser_model_i (.sys_clk, .sys_rst,
		.frame_valid, .frame_hdr);
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// bus write: address and data together, then wait for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic setw(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, 4'hF, rs);
		check("write resp", rs, IPACE_RESP_OKAY);
	endtask
	// expected outcome of one three-way or address criterion
	function automatic logic tri_ok(input logic [1:0] c, input logic v);
		return c == 2'h0 || (c == 2'h1 && !v) || (c == 2'h2 && v);
	endfunction
	function automatic logic adr_ok(input logic [1:0] c,
		input logic [31:0] ip, input logic [31:0] a, input logic [31:0] m);
		return c == 2'h0 || (c == 2'h1 && ip == a) ||
			(c == 2'h2 && ((ip ^ a) & m) == 32'h0);
	endfunction
	function automatic ipace_verdict_t expect_of(input ipace_frame_t h);
		ipace_verdict_t v;
		logic [2:0] pm;
		logic pok;
		pm = ctrl[IPACE_PM_POS +: 3];
		pok = pm == 3'h0 || (pm == 3'h1 && h.proto == pv[7:0]) ||
			(pm == 3'h2 && h.proto == 8'h01) ||
			(pm == 3'h3 && h.proto == 8'h11) ||
			(pm == 3'h4 && h.proto == 8'h06);
		v = '0;
		case (ctrl[IPACE_FT_POS +: 2])
			2'h0: v.hit = 1'b1;
			2'h2: v.hit = h.ftype != 2'h1;
			2'h1: v.hit = h.ftype == 2'h1 && pok &&
				tri_ok(ctrl[IPACE_TTL_POS +: 2], h.ttl != 8'h0) &&
				tri_ok(ctrl[IPACE_FRG_POS +: 2],
				h.more_frag || h.frag_ofs != 13'h0) &&
				tri_ok(ctrl[IPACE_OPT_POS +: 2], h.has_opts) &&
				adr_ok(ctrl[IPACE_SRC_POS +: 2], h.src_ip, sa, sm) &&
				adr_ok(ctrl[IPACE_DST_POS +: 2], h.dst_ip, da, dm);
			default: v.hit = 1'b0;
		endcase
		if (ctrl[IPACE_FT_POS +: 2] == 2'h1) begin
			v.l4_icmp = v.hit && pm == 3'h2;
			v.l4_udp = v.hit && pm == 3'h3;
			v.l4_tcp = v.hit && pm == 3'h4;
		end
		return v;
	endfunction
	// address equal, off only in masked-out bits, off by one bit, random
	function automatic logic [31:0] near(input logic [31:0] a,
		input logic [31:0] m);
		case ($urandom_range(0, 3))
			0: return a;
			1: return a ^ ($urandom & ~m);
			2: return a ^ (32'h1 << $urandom_range(0, 31));
			default: return $urandom;
		endcase
	endfunction
	function automatic ipace_frame_t gen_frame();
		ipace_frame_t h;
		logic [7:0] pl[5];
		logic [7:0] tl[4];
		pl = '{pv[7:0], 8'h01, 8'h06, 8'h11, 8'($urandom)};
		tl = '{8'h00, 8'h01, 8'hFF, 8'($urandom)};
		h.ftype = $urandom_range(0, 3) != 0 ? 2'h1 : 2'($urandom);
		h.proto = pl[$urandom_range(0, 4)];
		h.ttl = tl[$urandom_range(0, 3)];
		h.more_frag = $urandom_range(0, 2) == 0;
		h.frag_ofs = 13'($urandom_range(0, 2) == 0 ? $urandom : 0);
		if ($urandom_range(0, 3) == 0)
			h.frag_ofs = 13'h1;
		h.has_opts = 1'($urandom);
		h.src_ip = near(sa, sm);
		h.dst_ip = near(da, dm);
		return h;
	endfunction
	// each verdict against the oldest expectation
	always @(posedge sys_clk) begin
		if (verdict_valid === 1'b1) begin
			check("queued", exp_q.size() != 0, 1);
			if (exp_q.size() != 0) begin
				ev = exp_q.pop_front();
				hits += ev.hit;
				check("verdict", verdict, ev);
			end
		end
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		give_verdict();
	end
	initial begin
		void'($urandom(19));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		sys_rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// reset words, then one unmapped word
		for (int a = 0; a <= 32; a += 4) begin
			rdw(8'(a), rd, rs);
			check("reset word", rd, 32'h0);
			check("read resp", rs, a == 32 ? IPACE_RESP_SLVERR : 2'h0);
		end
		// byte lanes 0 and 2 only
		setw(IPACE_SRC_ADDR_OFS, 32'h1122_3344);
		wr(IPACE_SRC_ADDR_OFS, 32'hAABB_CCDD, 4'h5, rs);
		rdw(IPACE_SRC_ADDR_OFS, rd, rs);
		check("lanes", rd, 32'h11BB_33DD);
		wr(8'h24, 32'hFFFF_FFFF, 4'hF, rs);
		check("unmapped resp", rs, IPACE_RESP_SLVERR);
		// reset in mid-run clears the held address words
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdw(IPACE_SRC_ADDR_OFS, rd, rs);
		check("reset again", rd, 32'h0);
		for (int n = 0; n < 200; n++) begin
			ctrl = '0;
			ctrl[IPACE_FT_POS +: 2] = $urandom_range(0, 9) == 9 ? 2'h3 :
				2'($urandom_range(0, 2));
			ctrl[IPACE_PM_POS +: 3] = 3'($urandom_range(0, 5));
			foreach (pos[i])
				ctrl[pos[i] +: 2] = $urandom_range(0, 9) == 9 ? 2'h3 :
					2'($urandom_range(0, 2));
			{pv, sa, da} = {$urandom, $urandom, $urandom};
			sm = 32'hFFFF_FFFF << $urandom_range(0, 32);
			dm = 32'hFFFF_FFFF << $urandom_range(0, 32);
			setw(IPACE_CTRL_OFS, ctrl);
			setw(IPACE_PROTO_OFS, pv);
			setw(IPACE_SRC_ADDR_OFS, sa);
			setw(IPACE_SRC_MASK_OFS, sm);
			setw(IPACE_DST_ADDR_OFS, da);
			setw(IPACE_DST_MASK_OFS, dm);
			rdw(IPACE_PROTO_OFS, rd, rs);
			check("proto", rd, {24'h0, pv[7:0]});
			repeat (5) begin
				f = gen_frame();
				exp_q.push_back(expect_of(f));
				ipace_parser_model_i.push(f, $urandom_range(0, 1) * 2);
			end
			for (int k = 0; k < 100 && exp_q.size() != 0; k++)
				@(posedge sys_clk);
			check("drained", exp_q.size(), 0);
			rdw(IPACE_STAT_OFS, rd, rs);
			check("stat", {rd[7], rd[0]}, {1'b1, ev.hit});
		end
		// read-only counter ignores the write and counts every hit
		setw(IPACE_HITS_OFS, 32'hFFFF_FFFF);
		rdw(IPACE_HITS_OFS, rd, rs);
		check("hits", rd, hits);
		give_verdict();
	end
endmodule
`default_nettype wire
